// ===== hw/tsc_consts.svh
// Register indices, field codes, error codes and timing figures of the sensor calibration mailbox
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// ****************************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************************
`define TSC_IDX_CMD        16'hC15C
`define TSC_IDX_UNIT       16'hC15D
`define TSC_IDX_OPID       16'hC15E
`define TSC_IDX_PASS       16'hC15F
`define TSC_IDX_STATUS     16'hC161
`define TSC_IDX_RESULT     16'hC162
`define TSC_IDX_ISENS      16'hC33C
`define TSC_IDX_IZERO      16'hC33D
`define TSC_IDX_ISPAN      16'hC33F
`define TSC_IDX_IUPPER     16'hC341
`define TSC_IDX_ILOWER     16'hC343
`define TSC_IDX_CSEL       16'hC346
`define TSC_IDX_CKIND      16'hC347
`define TSC_IDX_CVAL       16'hC348
`define TSC_IDX_MODE       16'hC350
`define TSC_IDX_MODEL      16'hC351

// ****************************************************************************
// Command, sensor, value-kind and mode codes
// ****************************************************************************
`define TSC_CMD_NONE       16'h0000
`define TSC_CMD_INFO       16'h0086
`define TSC_CMD_CAL        16'h0087
`define TSC_SENS_MIN       16'h0001
`define TSC_SENS_TEMP      16'h0003
`define TSC_KIND_ZERO      16'h0000
`define TSC_KIND_SPAN      16'h0001
`define TSC_KIND_FIXED     16'h0002
`define TSC_UNIT_MIN       16'h0001
`define TSC_UNIT_MAX       16'h000A
`define TSC_MODE_CAL       16'h00FF
`define TSC_MODE_ONLINE    16'h0000
`define TSC_MODEL_FIX_LSB  16

// ****************************************************************************
// Error codes placed in the status reply
// ****************************************************************************
`define TSC_ERR_UNKNOWN    16'h0101
`define TSC_ERR_PARAM      16'h0102
`define TSC_ERR_LOCKED     16'h0103
`define TSC_ERR_REFUSED    16'h0104
`define TSC_ERR_NORESP     16'h0105

// ****************************************************************************
// Bus codes and timing
// ****************************************************************************
`define TSC_HSIZE_WORD     3'h2
`define TSC_HRESP_OKAY     1'h0
`define TSC_TMO_US         1000
`define TSC_CLK_MHZ        250

`endif

// ===== hw/tsc_pkg.sv
// Types shared by the sensor calibration mailbox and its transmitter link
package tsc_pkg;

  // Request towards the transmitter link
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [15:0] unit;
    logic [15:0] sensor;
    logic [15:0] kind;
    logic [31:0] value;
  } tsc_xreq_t;

  // Answer from the transmitter link
  typedef struct packed {
    logic        done;
    logic        ok;
    logic [15:0] err;
    logic [15:0] sensor;
    logic [31:0] zero;
    logic [31:0] span;
    logic [31:0] upper;
    logic [31:0] lower;
  } tsc_xrsp_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ISSUE = 5'b00010,
    S_WAIT  = 5'b00100,
    S_REPLY = 5'b01000,
    S_CLEAR = 5'b10000
  } tsc_state_t;

endpackage

// ===== hw/tsc_mailbox.sv
// Command mailbox for transmitter sensor information and calibration, AHB-Lite slave
//
// Behaviour
// [R1] Sensor select: 1 DP, 2 SP, 3 temperature
// [R2] Value kind 0/1/2; 2 only for temperature
// [R3] Setpoint sent as float, meaning per kind
// [R4] Command 134 fetches selected sensor information
// [R5] Host writes sensor select before command
// [R6] Transmitter number 1..10, then user, passcode
// [R7] Command register cleared when command finishes
// [R8] Info success status 134, else error code
// [R9] Result 0 on error, else transmitter number
// [R10] Info replies: type, zero, span, limits
// [R11] Invalid sensor parameters give info error
// [R12] Command 135 sends calibration registers out
// [R13] One calibration command per sensor
// [R14] Integrated models refuse span or fixed
// [R15] Calibration success status 135, else error
// [R16] Invalid calibration parameters give error
// [R17] Fixed temperature only on capable model
// [R18] Information comes from querying the transmitter
// [R19] Calibration writes only in calibrate mode
// [R20] Replies updated before command register clears
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "tsc_consts.svh"

module tsc_mailbox #(
  parameter int XFER_TMO_CYC = `TSC_TMO_US * `TSC_CLK_MHZ
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rstn,
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic      [31:0]        o_hrdata,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  output tsc_pkg::tsc_xreq_t      o_xreq,
  input  wire tsc_pkg::tsc_xrsp_t i_xrsp
);
  import tsc_pkg::*;

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  // Word decode; the index is the register number, byte address four times it
  function automatic logic addr_hit(input logic [31:0] a, input logic [15:0] idx);
    addr_hit = (a[31:18] == 14'h0000) && (a[17:2] == idx);
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ****************************************************************************
  // Storage
  // ****************************************************************************
  tsc_state_t  state_r;
  tsc_state_t  state_nxt;
  logic [15:0] cmd_r;
  logic [15:0] unit_r;
  logic [15:0] opid_r;
  logic [15:0] pass_r;
  logic [15:0] status_r;
  logic [15:0] result_r;
  logic [15:0] isens_r;
  logic [31:0] izero_r;
  logic [31:0] ispan_r;
  logic [31:0] iupper_r;
  logic [31:0] ilower_r;
  logic [15:0] csel_r;
  logic [15:0] ckind_r;
  logic [31:0] cval_r;
  logic [15:0] mode_r;
  logic [31:0] model_r;
  logic        job_info_r;
  logic [15:0] job_unit_r;
  logic        fail_r;
  logic [15:0] err_r;
  logic [31:0] tmo_r;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic        rd_pend_r;
  logic [31:0] rd_addr_r;

  // ****************************************************************************
  // Bus decode
  // ****************************************************************************
  // Only whole-word writes are accepted; other writes complete OKAY and do nothing, reads of any size are taken
  wire addr_ph  = i_hsel && i_htrans[1] && i_hready;
  wire wr_take  = addr_ph && i_hwrite && (i_hsize == `TSC_HSIZE_WORD);
  wire rd_take  = addr_ph && !i_hwrite;
  wire busy     = (state_r != S_IDLE);
  // Parameters are frozen while a command runs so the job sees one snapshot
  wire wr_ok    = wr_pend_r && !busy;
  wire w_cmd    = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_CMD);
  wire w_unit   = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_UNIT);
  wire w_opid   = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_OPID);
  wire w_pass   = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_PASS);
  wire w_csel   = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_CSEL);
  wire w_ckind  = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_CKIND);
  wire w_cval   = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_CVAL);
  wire w_mode   = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_MODE);
  wire w_model  = wr_ok && addr_hit(wr_addr_r, `TSC_IDX_MODEL);

  // Read mux; unmapped words read as zero
  logic [31:0] rd_mux;
  assign rd_mux =
    addr_hit(rd_addr_r, `TSC_IDX_CMD)    ? {16'h0000, cmd_r}    :
    addr_hit(rd_addr_r, `TSC_IDX_UNIT)   ? {16'h0000, unit_r}   :
    addr_hit(rd_addr_r, `TSC_IDX_OPID)   ? {16'h0000, opid_r}   :
    addr_hit(rd_addr_r, `TSC_IDX_PASS)   ? {16'h0000, pass_r}   :
    addr_hit(rd_addr_r, `TSC_IDX_STATUS) ? {16'h0000, status_r} :
    addr_hit(rd_addr_r, `TSC_IDX_RESULT) ? {16'h0000, result_r} :
    addr_hit(rd_addr_r, `TSC_IDX_ISENS)  ? {16'h0000, isens_r}  :
    addr_hit(rd_addr_r, `TSC_IDX_IZERO)  ? izero_r              :
    addr_hit(rd_addr_r, `TSC_IDX_ISPAN)  ? ispan_r              :
    addr_hit(rd_addr_r, `TSC_IDX_IUPPER) ? iupper_r             :
    addr_hit(rd_addr_r, `TSC_IDX_ILOWER) ? ilower_r             :
    addr_hit(rd_addr_r, `TSC_IDX_CSEL)   ? {16'h0000, csel_r}   :
    addr_hit(rd_addr_r, `TSC_IDX_CKIND)  ? {16'h0000, ckind_r}  :
    addr_hit(rd_addr_r, `TSC_IDX_CVAL)   ? cval_r               :
    addr_hit(rd_addr_r, `TSC_IDX_MODE)   ? {16'h0000, mode_r}   :
    addr_hit(rd_addr_r, `TSC_IDX_MODEL)  ? model_r              : 32'h0000_0000;

  // ****************************************************************************
  // Command checks
  // ****************************************************************************
  wire         is_info   = (cmd_r == `TSC_CMD_INFO);
  wire         is_cal    = (cmd_r == `TSC_CMD_CAL);
  wire         start     = (state_r == S_IDLE) && (cmd_r != `TSC_CMD_NONE);
  wire         unit_ok   = in_range(unit_r, `TSC_UNIT_MIN, `TSC_UNIT_MAX);      // [R6]
  wire         sens_ok   = in_range(csel_r, `TSC_SENS_MIN, `TSC_SENS_TEMP);     // [R1]
  wire         kind_ok   = in_range(ckind_r, `TSC_KIND_ZERO, `TSC_KIND_SPAN) ||
                           ((ckind_r == `TSC_KIND_FIXED) && (csel_r == `TSC_SENS_TEMP)); // [R2]
  wire         param_bad = !unit_ok || !sens_ok || (is_cal && !kind_ok);       // [R11] [R16]
  wire [3:0]   uidx      = unit_ok ? 4'(unit_r[3:0] - 4'h1) : 4'h0;
  wire         integ     = model_r[uidx];
  wire         fixcap    = model_r[`TSC_MODEL_FIX_LSB + 32'(uidx)];
  wire         locked    = is_cal && (mode_r != `TSC_MODE_CAL);                 // [R19]
  wire         refused   = is_cal && ((integ && (ckind_r != `TSC_KIND_ZERO)) || // [R14]
                           ((ckind_r == `TSC_KIND_FIXED) && !fixcap));          // [R17]
  wire [15:0]  chk_err   = !(is_info || is_cal) ? `TSC_ERR_UNKNOWN :
                           param_bad            ? `TSC_ERR_PARAM   :
                           locked               ? `TSC_ERR_LOCKED  : `TSC_ERR_REFUSED;
  wire         chk_fail  = !(is_info || is_cal) || param_bad || locked || refused;
  wire         tmo_hit   = (tmo_r == 32'(XFER_TMO_CYC - 1));
  wire         rsp_ok    = i_xrsp.done && i_xrsp.ok;

  // ****************************************************************************
  // Sequencer
  // ****************************************************************************
  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:  if (start) state_nxt = chk_fail ? S_REPLY : S_ISSUE;
      S_ISSUE: state_nxt = S_WAIT;
      S_WAIT:  if (i_xrsp.done || tmo_hit) state_nxt = S_REPLY;
      S_REPLY: state_nxt = S_CLEAR;
      S_CLEAR: state_nxt = S_IDLE;
    endcase
  end

  // State, job snapshot and outcome
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r    <= S_IDLE;
      job_info_r <= 1'b0;
      job_unit_r <= 16'h0000;
      fail_r     <= 1'b0;
      err_r      <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        job_info_r <= is_info;
        job_unit_r <= unit_r;
        fail_r     <= chk_fail;
        err_r      <= chk_err;
      end else if ((state_r == S_WAIT) && i_xrsp.done) begin
        fail_r <= !i_xrsp.ok;
        err_r  <= i_xrsp.err;
      end else if ((state_r == S_WAIT) && tmo_hit) begin
        fail_r <= 1'b1;
        err_r  <= `TSC_ERR_NORESP;
      end
    end
  end

  // Response watchdog; a silent transmitter must not hang the mailbox
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) tmo_r <= 32'h0000_0000;
    else tmo_r <= (state_r == S_WAIT) ? tmo_r + 32'h0000_0001 : 32'h0000_0000;
  end

  // Request to the transmitter link, one-cycle valid
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_xreq <= '0;
    end else begin
      o_xreq.valid <= (state_nxt == S_ISSUE);                        // [R4] [R12] [R18]
      if (start) begin
        o_xreq.wr     <= is_cal;                                     // [R12]
        o_xreq.unit   <= unit_r;
        o_xreq.sensor <= csel_r;                                     // [R1] [R4]
        o_xreq.kind   <= ckind_r;                                    // [R3]
        o_xreq.value  <= cval_r;                                     // [R3]
      end
    end
  end

  // Replies first, command cleared one cycle later
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_r <= 16'h0000;
      result_r <= 16'h0000;
    end else if (state_r == S_REPLY) begin
      status_r <= fail_r ? err_r : (job_info_r ? `TSC_CMD_INFO : `TSC_CMD_CAL); // [R8] [R15] [R20]
      result_r <= fail_r ? 16'h0000 : job_unit_r;                                // [R9]
    end
  end

  // Information replies straight from the transmitter answer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      isens_r  <= 16'h0000;
      izero_r  <= 32'h0000_0000;
      ispan_r  <= 32'h0000_0000;
      iupper_r <= 32'h0000_0000;
      ilower_r <= 32'h0000_0000;
    end else if ((state_r == S_WAIT) && rsp_ok && job_info_r) begin
      isens_r  <= i_xrsp.sensor;                                     // [R10] [R18]
      izero_r  <= i_xrsp.zero;
      ispan_r  <= i_xrsp.span;
      iupper_r <= i_xrsp.upper;
      ilower_r <= i_xrsp.lower;
    end
  end

  // ****************************************************************************
  // Software registers
  // ****************************************************************************
  // Command register; hardware clear ends the job
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) cmd_r <= `TSC_CMD_NONE;
    else if (state_r == S_CLEAR) cmd_r <= `TSC_CMD_NONE;             // [R7] [R20]
    else if (w_cmd) cmd_r <= i_hwdata[15:0];
  end

  // Parameter and calibration registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      unit_r  <= 16'h0000;
      opid_r  <= 16'h0000;
      pass_r  <= 16'h0000;
      csel_r  <= 16'h0000;
      ckind_r <= `TSC_KIND_ZERO;
      cval_r  <= 32'h0000_0000;
      mode_r  <= `TSC_MODE_ONLINE;
      model_r <= 32'h0000_0000;
    end else begin
      if (w_unit)  unit_r  <= i_hwdata[15:0];
      if (w_opid)  opid_r  <= i_hwdata[15:0];
      if (w_pass)  pass_r  <= i_hwdata[15:0];
      if (w_csel)  csel_r  <= i_hwdata[15:0];
      if (w_ckind) ckind_r <= i_hwdata[15:0];
      if (w_cval)  cval_r  <= i_hwdata;
      if (w_mode)  mode_r  <= i_hwdata[15:0];
      if (w_model) model_r <= i_hwdata;
    end
  end

  // ****************************************************************************
  // AHB-Lite slave
  // ****************************************************************************
  // Writes commit at end of data phase; reads add one wait so they see that write
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 32'h0000_0000;
      rd_pend_r   <= 1'b0;
      rd_addr_r   <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hrdata    <= 32'h0000_0000;
      o_hresp     <= `TSC_HRESP_OKAY;
    end else begin
      wr_pend_r   <= wr_take;
      rd_pend_r   <= rd_take;
      o_hreadyout <= !rd_take;
      o_hresp     <= `TSC_HRESP_OKAY;
      if (wr_take) wr_addr_r <= i_haddr;
      if (rd_take) rd_addr_r <= i_haddr;
      if (rd_pend_r) o_hrdata <= rd_mux;
    end
  end

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  wire good_start = start && !chk_fail;

  sequence seq_reply_then_clear;
    (cmd_r != `TSC_CMD_NONE) ##1 (cmd_r == `TSC_CMD_NONE);
  endsequence

  sequence seq_answer_ok;
    (state_r == S_WAIT) && rsp_ok;
  endsequence

  a_clear_after_reply: assert property ((state_r == S_REPLY) |=> seq_reply_then_clear) // [R7] [R20]
    else $error("command register not cleared right after replies");

  a_info_status_ok: assert property (seq_answer_ok and job_info_r // [R8]
      |-> ##2 (status_r == `TSC_CMD_INFO) && (result_r == job_unit_r))
    else $error("info success status wrong");

  a_cal_status_ok: assert property (seq_answer_ok and !job_info_r // [R15]
      |-> ##2 (status_r == `TSC_CMD_CAL) && (result_r == job_unit_r))
    else $error("calibration success status wrong");

  a_result_zero_err: assert property ((state_r == S_REPLY) && fail_r |=> (result_r == 16'h0000)) // [R9]
    else $error("result not zero on error");

  a_info_copy_regs: assert property (seq_answer_ok and job_info_r // [R10]
      |=> (izero_r == $past(i_xrsp.zero)) && (ilower_r == $past(i_xrsp.lower))
          && (isens_r == $past(i_xrsp.sensor)))
    else $error("info replies not taken from answer");

  a_info_query: assert property (good_start && is_info // [R4] [R18]
      |=> o_xreq.valid && !o_xreq.wr && (o_xreq.sensor == $past(csel_r)))
    else $error("info query not issued");

  a_cal_send: assert property (good_start && is_cal // [R12] [R3]
      |=> o_xreq.valid && o_xreq.wr && (o_xreq.value == $past(cval_r)) && (o_xreq.kind == $past(ckind_r)))
    else $error("calibration request wrong");

  a_locked_block: assert property (start && is_cal && !param_bad && (mode_r != `TSC_MODE_CAL) // [R19]
      |=> !o_xreq.valid [*3] ##0 (status_r == `TSC_ERR_LOCKED))
    else $error("calibration not blocked outside calibrate mode");

  a_model_refuse: assert property (start && is_cal && !param_bad && !locked && integ // [R14]
      && (ckind_r == `TSC_KIND_SPAN) |-> ##2 (status_r == `TSC_ERR_REFUSED) && !o_xreq.valid)
    else $error("integrated model span not refused");

  a_param_bad: assert property (start && (is_info || is_cal) && param_bad // [R11] [R16] [R2]
      |-> ##2 (status_r == `TSC_ERR_PARAM) && (result_r == 16'h0000))
    else $error("invalid parameters not reported");

  // Failure paths past the checks, and the unknown-command check
  a_xfail_status: assert property ((state_r == S_WAIT) && i_xrsp.done && !i_xrsp.ok // [R8] [R15] [R9]
      |-> ##2 (status_r == $past(i_xrsp.err, 2)) && (result_r == 16'h0000))
    else $error("transmitter error code not reported");

  a_timeout_err: assert property ((state_r == S_WAIT) && tmo_hit && !i_xrsp.done // [R9]
      |-> ##2 (status_r == `TSC_ERR_NORESP) && (result_r == 16'h0000))
    else $error("silent transmitter not reported");

  a_unknown_cmd: assert property (start && !(is_info || is_cal) // [R9]
      |-> ##2 (status_r == `TSC_ERR_UNKNOWN) && (result_r == 16'h0000) && !o_xreq.valid)
    else $error("unknown command not rejected");

  // Info replies move only on a good info answer
  a_info_hold: assert property (!((state_r == S_WAIT) && rsp_ok && job_info_r) // [R10]
      |=> $stable(izero_r) && $stable(iupper_r) && $stable(isens_r))
    else $error("info replies changed without an info answer");

endmodule

// ===== bench/tsc_xmtr_model.sv
// Behavioural transmitter that answers the mailbox link requests
`timescale 1ns/1ps
module tsc_xmtr_model (
  input  wire logic               i_mclk,
  input  wire logic               i_rstn,
  input  wire tsc_pkg::tsc_xreq_t i_xreq,
  input  wire logic [1:0]         i_mode,
  input  wire logic [1:0]         i_delay,
  input  wire logic [15:0]        i_err,
  output tsc_pkg::tsc_xrsp_t      o_xrsp
);
  import tsc_pkg::*;
  tsc_xreq_t   req_r;
  logic        busy_r;
  logic [1:0]  wait_r;
  logic [31:0] junk_r;
  logic        fire;
  // ****************
  // Request capture
  // ****************
  // Mode 2 stays silent so that the mailbox timeout is exercised
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_r <= 1'b0;
      wait_r <= 2'h0;
      req_r  <= '0;
      junk_r <= 32'h0;
    end else begin
      junk_r <= junk_r + 32'h9E3779B9;
      if (i_xreq.valid && i_mode != 2'h2) begin
        busy_r <= 1'b1;
        wait_r <= i_delay;
        req_r  <= i_xreq;
      end else if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else begin
        busy_r <= 1'b0;
      end
    end
  end
  // Fields mean nothing without done, so they roll instead of holding
  assign fire   = busy_r && (wait_r == 2'h0);
  assign o_xrsp = fire ? {1'b1, i_mode == 2'h0, i_err, req_r.sensor,
                          8'h11, req_r.unit[7:0], req_r.sensor, 8'h22, req_r.unit[7:0], req_r.sensor,
                          8'h33, req_r.unit[7:0], req_r.sensor, 8'h44, req_r.unit[7:0], req_r.sensor}
                       : {1'b0, junk_r[0], junk_r[15:0], ~junk_r[15:0], {4{junk_r}}};
endmodule

// ===== bench/transmitter_sensor_cal_cmd_tb_top.sv
// Self-checking bench for the sensor calibration mailbox
`timescale 1ns/1ps
`include "tsc_consts.svh"
module transmitter_sensor_cal_cmd_tb_top;
  import tsc_pkg::*;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = `TSC_HSIZE_WORD;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  tsc_xreq_t   xreq;
  tsc_xreq_t   last_req;
  tsc_xrsp_t   xrsp;
  logic [1:0]  xmode    = 2'h0;
  logic [1:0]  xdly     = 2'h0;
  logic [15:0] xerr     = 16'h02A5;
  logic [15:0] mode_v;
  logic [31:0] model_v;
  logic [15:0] last_es;
  logic [31:0] info_v [5] = '{default: 32'h0};
  logic [31:0] r;
  int          n_errors = 0;
  int          compares = 0;
  int          n_req    = 0;
  int          cycles   = 0;
  integer      seed     = 32'hdb48;

  tsc_mailbox #(.XFER_TMO_CYC(20)) dut (.i_mclk(clk), .i_rstn(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_xreq(xreq), .i_xrsp(xrsp));
  tsc_xmtr_model xmtr (.i_mclk(clk), .i_rstn(rst_n), .i_xreq(xreq), .i_mode(xmode), .i_delay(xdly),
    .i_err(xerr), .o_xrsp(xrsp));

  // ****************
  // Clock, request monitor, hang guard
  // ****************
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (xreq.valid === 1'b1) begin
      last_req <= xreq;
      n_req    <= n_req + 1;
    end
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {14'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, `TSC_HRESP_OKAY}, "hresp");
  endtask

  // Error the mailbox must find before asking the transmitter
  function automatic logic [15:0] pre_err(logic [15:0] c, logic [15:0] u, logic [15:0] s, logic [15:0] k);
    if (c != `TSC_CMD_INFO && c != `TSC_CMD_CAL) return `TSC_ERR_UNKNOWN;
    if (u < 16'h1 || u > 16'hA || s < 16'h1 || s > 16'h3) return `TSC_ERR_PARAM;
    if (c == `TSC_CMD_INFO) return 16'h0;
    if (k > 16'h2 || (k == 16'h2 && s != 16'h3)) return `TSC_ERR_PARAM;
    if (mode_v != `TSC_MODE_CAL) return `TSC_ERR_LOCKED;
    if ((model_v[u - 1] && k != 16'h0) || (k == 16'h2 && !model_v[15 + u])) return `TSC_ERR_REFUSED;
    return 16'h0;
  endfunction

  // One complete command: parameters, command, poll, replies
  task automatic job(input logic [15:0] c, u, s, k, md, input logic [31:0] mc, input logic [1:0] xm);
    logic [31:0] rd;
    logic [31:0] v;
    logic [15:0] pe;
    int          n0;
    v       = $random(seed);
    mode_v  = md;
    model_v = mc;
    pe      = pre_err(c, u, s, k);
    last_es = (pe != 16'h0) ? pe : (xm == 2'h1) ? xerr : (xm == 2'h2) ? `TSC_ERR_NORESP : c;
    xmode  <= xm;
    xdly   <= v[1:0];
    bus(1'b1, `TSC_IDX_MODE, {16'h0, md}, rd);
    bus(1'b1, `TSC_IDX_MODEL, mc, rd);
    bus(1'b1, `TSC_IDX_CSEL, {16'h0, s}, rd);
    bus(1'b1, `TSC_IDX_CKIND, {16'h0, k}, rd);
    bus(1'b1, `TSC_IDX_CVAL, v, rd);
    bus(1'b1, `TSC_IDX_UNIT, {16'h0, u}, rd);
    bus(1'b1, `TSC_IDX_OPID, {16'h0, v[31:16]}, rd);
    bus(1'b1, `TSC_IDX_PASS, {16'h0, v[23:8]}, rd);
    bus(1'b0, `TSC_IDX_PASS, 32'h0, rd);
    chk(rd, {16'h0, v[23:8]}, "passcode readback");
    n0 = n_req;
    bus(1'b1, `TSC_IDX_CMD, {16'h0, c}, rd);
    rd = 32'h1;
    while (rd !== 32'h0) bus(1'b0, `TSC_IDX_CMD, 32'h0, rd);
    bus(1'b0, `TSC_IDX_STATUS, 32'h0, rd);
    chk(rd, {16'h0, last_es}, "status");
    bus(1'b0, `TSC_IDX_RESULT, 32'h0, rd);
    chk(rd, (last_es == c) ? {16'h0, u} : 32'h0, "result");
    chk(32'(n_req - n0), (pe == 16'h0) ? 32'h1 : 32'h0, "request count");
    if (pe == 16'h0) begin
      chk({31'h0, last_req.wr}, {31'h0, c == `TSC_CMD_CAL}, "request kind");
      chk({last_req.unit, last_req.sensor}, {u, s}, "request target");
      if (c == `TSC_CMD_CAL) chk(last_req.value, v, "setpoint");
      if (c == `TSC_CMD_CAL) chk({16'h0, last_req.kind}, {16'h0, k}, "value kind");
    end
    if (c == `TSC_CMD_INFO && last_es == c) begin
      info_v[0] = {16'h0, s};
      for (int i = 1; i < 5; i++) info_v[i] = {8'(8'h11 * i), u[7:0], s};
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, (i == 0) ? `TSC_IDX_ISENS : 16'(`TSC_IDX_IZERO + 2 * (i - 1)), 32'h0, rd);
      chk(rd, info_v[i], "info register");
    end
    $display("test cmd %h unit %h sensor %h done", c, u, s);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `TSC_IDX_CMD, 32'h0, r);
    chk(r, 32'h0, "command after reset");
    job(`TSC_CMD_INFO, 16'h1, 16'h1, 16'h0, 16'h0, 32'h0, 2'h0);
    job(`TSC_CMD_INFO, 16'hA, 16'h3, 16'h1, 16'h0, 32'h0, 2'h0);
    job(`TSC_CMD_INFO, 16'h0, 16'h2, 16'h0, 16'h0, 32'h0, 2'h0);
    job(`TSC_CMD_INFO, 16'hB, 16'h2, 16'h0, 16'h0, 32'h0, 2'h0);
    job(`TSC_CMD_INFO, 16'h2, 16'h4, 16'h0, 16'h0, 32'h0, 2'h0);
    job(`TSC_CMD_CAL, 16'h3, 16'h1, 16'h0, 16'h0, 32'h0, 2'h0);
    job(`TSC_CMD_CAL, 16'h3, 16'h1, 16'h0, 16'hFF, 32'h0, 2'h0);
    job(`TSC_CMD_CAL, 16'h3, 16'h2, 16'h1, 16'hFF, 32'h4, 2'h0);
    job(`TSC_CMD_CAL, 16'h3, 16'h1, 16'h2, 16'hFF, 32'h0, 2'h0);
    job(`TSC_CMD_CAL, 16'h4, 16'h3, 16'h2, 16'hFF, 32'h80000, 2'h0);
    job(`TSC_CMD_CAL, 16'h4, 16'h3, 16'h2, 16'hFF, 32'h0, 2'h0);
    job(`TSC_CMD_CAL, 16'h5, 16'h3, 16'h3, 16'hFF, 32'h0, 2'h0);
    job(`TSC_CMD_INFO, 16'h6, 16'h2, 16'h0, 16'h0, 32'h0, 2'h1);
    job(`TSC_CMD_CAL, 16'h7, 16'h2, 16'h1, 16'hFF, 32'h0, 2'h2);
    job(16'h0005, 16'h1, 16'h1, 16'h0, 16'hFF, 32'h0, 2'h0);
    job(`TSC_CMD_CAL, 16'h2, 16'h1, 16'h1, 16'hFF, 32'h0, 2'h0);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      job(r[1] ? `TSC_CMD_CAL : `TSC_CMD_INFO, 16'(r[19:16] % 12), 16'(r[4:2] % 5), 16'(r[6:5]),
          r[7] ? 16'hFF : 16'h0, $random(seed), 2'(r[9:8] % 3));
    end
    // Read-only reply and an unmapped word must both ignore writes
    bus(1'b1, `TSC_IDX_STATUS, 32'hFFFF, r);
    bus(1'b0, `TSC_IDX_STATUS, 32'h0, r);
    chk(r, {16'h0, last_es}, "read-only status");
    bus(1'b1, 16'h0100, 32'h1234ABCD, r);
    bus(1'b0, 16'h0100, 32'h0, r);
    chk(r, 32'h0, "unmapped word");
    complete_run();
  end
endmodule
